// file: rtl/lbes_core.sv
// Brake opening, emergency and maintenance running, and torque-off supervision
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - With type 0 the brake opens once frequency reaches the threshold and the delay has passed.
// - With type 1 the output current must also reach the opening current before the brake opens.
// - An emergency input enters emergency running at the emergency frequency, default 20.00 Hz.
// - In emergency running the fourth ramp time set is selected.
// - A maintenance input runs at the held maintenance frequency, default 20.00 Hz.
// - With emergency handling 0 there is no output while the emergency input is active.
// - With emergency handling 1 the drive runs on UPS at the emergency frequency.
// - An ascending correction frequency of 0.00 to 3.00 Hz is held, default 0.00 Hz.
// - A descending correction frequency of 0.00 to 3.00 Hz is held, default 0.00 Hz.
// - An emergency validity time of 0.0 to 500.0 s is held, default 10.0 s.
// - An emergency invalid time of 0.0 to 1000.0 s is held, default 180.0 s.
// - Both torque-off channels active trigger torque off and stop output current.
// - Both channels inactive let the drive run normally.
// - One channel alone raises the mismatch fault with type 1, 2 or 3.
// - Forward rotation uses the rising thresholds and reverse the falling ones.
module lbes_core #(
  parameter int BRAKE_UNIT_CYC = lbes_pkg::BRAKE_UNIT_CYCLES,
  parameter int SWITCH_CYC = lbes_pkg::SWITCH_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Drive feedback
  input wire logic runCmd,
  input wire logic directionReverse,
  input wire logic [lbes_pkg::FREQ_W-1:0] outputFreq,
  input wire logic [lbes_pkg::CURR_W-1:0] outputCurrent,
  input wire logic [lbes_pkg::FREQ_W-1:0] normalFreq,
  input wire logic [lbes_pkg::RAMP_W-1:0] normalRampSet,
  // Brake settings
  input wire logic brakeOpenType,
  input wire logic [lbes_pkg::TIME_W-1:0] brakeOpenDelay,
  input wire logic [lbes_pkg::FREQ_W-1:0] brakeOpenFreqUp,
  input wire logic [lbes_pkg::FREQ_W-1:0] brakeOpenFreqDown,
  input wire logic [lbes_pkg::CURR_W-1:0] brakeOpenCurrent,
  // Held parameter load
  input wire logic paramLoad,
  input wire logic [lbes_pkg::FREQ_W-1:0] emergencyRunFreqIn,
  input wire logic [lbes_pkg::FREQ_W-1:0] maintenanceRunFreqIn,
  input wire logic emergencyHandlingSelectIn,
  input wire logic [lbes_pkg::FREQ_W-1:0] ascendCorrectionFreqIn,
  input wire logic [lbes_pkg::FREQ_W-1:0] descendCorrectionFreqIn,
  input wire logic [lbes_pkg::TIME_W-1:0] emergencyValidTimeIn,
  input wire logic [lbes_pkg::TIME_W-1:0] emergencyInvalidTimeIn,
  // Pins
  input wire logic emergencyPin,
  input wire logic maintenancePin,
  input wire logic torqueOffChannelA,
  input wire logic torqueOffChannelB,
  input wire logic faultClear,
  // Drive commands
  output logic brakeOpen,
  output logic outputEnable,
  output logic [lbes_pkg::FREQ_W-1:0] freqSetpoint,
  output logic [lbes_pkg::RAMP_W-1:0] rampSet,
  output logic [1:0] runMode,
  output logic torqueOffActive,
  output logic torqueOffMismatchFault,
  output logic [lbes_pkg::FTYPE_W-1:0] faultTypeMonitor,
  // Held parameters
  output logic [lbes_pkg::FREQ_W-1:0] emergencyRunFreq,
  output logic [lbes_pkg::FREQ_W-1:0] maintenanceRunFreq,
  output logic emergencyHandlingSelect,
  output logic [lbes_pkg::FREQ_W-1:0] ascendCorrectionFreq,
  output logic [lbes_pkg::FREQ_W-1:0] descendCorrectionFreq,
  output logic [lbes_pkg::TIME_W-1:0] emergencyValidTime,
  output logic [lbes_pkg::TIME_W-1:0] emergencyInvalidTime
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 4;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinFilt;
  assign pinRaw = {torqueOffChannelB, torqueOffChannelA, maintenancePin, emergencyPin};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : gSync
      logic [2:0] sync_reg;
      logic [2:0] sync_next;
      logic filt_reg;
      logic filt_next;
      always_comb begin
        sync_next = {sync_reg[1:0], pinRaw[gi]};
        filt_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : filt_reg;
      end
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync_reg <= 3'h0;
          filt_reg <= 1'b0;
        end else begin
          sync_reg <= sync_next;
          filt_reg <= filt_next;
        end
      end
      assign pinFilt[gi] = filt_reg;
    end
  endgenerate
  logic emergOn;
  logic maintOn;
  logic chanA;
  logic chanB;
  assign emergOn = pinFilt[0];
  assign maintOn = pinFilt[1];
  assign chanA = pinFilt[2];
  assign chanB = pinFilt[3];

  // ****************************************
  // Held parameters
  // ****************************************
  logic [lbes_pkg::FREQ_W-1:0] emFreq_reg, emFreq_next, mtFreq_reg, mtFreq_next;
  logic [lbes_pkg::FREQ_W-1:0] ascFreq_reg, ascFreq_next, dscFreq_reg, dscFreq_next;
  logic [lbes_pkg::TIME_W-1:0] vTime_reg, vTime_next, iTime_reg, iTime_next;
  logic handling_reg, handling_next;

  always_comb begin
    emFreq_next = emFreq_reg;
    mtFreq_next = mtFreq_reg;
    ascFreq_next = ascFreq_reg;
    dscFreq_next = dscFreq_reg;
    vTime_next = vTime_reg;
    iTime_next = iTime_reg;
    handling_next = handling_reg;
    if (paramLoad) begin
      emFreq_next = (emergencyRunFreqIn > lbes_pkg::RUN_FREQ_MAX) ?
                    lbes_pkg::RUN_FREQ_MAX : emergencyRunFreqIn;
      mtFreq_next = (maintenanceRunFreqIn > lbes_pkg::RUN_FREQ_MAX) ?
                    lbes_pkg::RUN_FREQ_MAX : maintenanceRunFreqIn;
      ascFreq_next = (ascendCorrectionFreqIn > lbes_pkg::CORR_FREQ_MAX) ?
                     lbes_pkg::CORR_FREQ_MAX : ascendCorrectionFreqIn;
      dscFreq_next = (descendCorrectionFreqIn > lbes_pkg::CORR_FREQ_MAX) ?
                     lbes_pkg::CORR_FREQ_MAX : descendCorrectionFreqIn;
      vTime_next = (emergencyValidTimeIn > lbes_pkg::VALID_TIME_MAX) ?
                   lbes_pkg::VALID_TIME_MAX : emergencyValidTimeIn;
      iTime_next = (emergencyInvalidTimeIn > lbes_pkg::INVALID_TIME_MAX) ?
                   lbes_pkg::INVALID_TIME_MAX : emergencyInvalidTimeIn;
      handling_next = emergencyHandlingSelectIn;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      emFreq_reg <= lbes_pkg::RUN_FREQ_DEF;
      mtFreq_reg <= lbes_pkg::RUN_FREQ_DEF;
      ascFreq_reg <= lbes_pkg::CORR_FREQ_DEF;
      dscFreq_reg <= lbes_pkg::CORR_FREQ_DEF;
      vTime_reg <= lbes_pkg::VALID_TIME_DEF;
      iTime_reg <= lbes_pkg::INVALID_TIME_DEF;
      handling_reg <= lbes_pkg::EMERG_HANDLING_DEF;
    end else begin
      emFreq_reg <= emFreq_next;
      mtFreq_reg <= mtFreq_next;
      ascFreq_reg <= ascFreq_next;
      dscFreq_reg <= dscFreq_next;
      vTime_reg <= vTime_next;
      iTime_reg <= iTime_next;
      handling_reg <= handling_next;
    end
  end

  // ****************************************
  // Torque-off supervision
  // ****************************************
  logic mismatch;
  logic mismatchLong;
  logic fault_reg, fault_next;
  logic [lbes_pkg::FTYPE_W-1:0] ftype_reg, ftype_next;
  assign mismatch = chanA ^ chanB;

  lbes_delay #(.W(lbes_pkg::CNT_W)) uMismatch (
    .clk(clk),
    .reset(reset),
    .run(mismatch),
    .tick(1'b1),
    .limit(lbes_pkg::CNT_W'(SWITCH_CYC - 1)),
    .done(mismatchLong)
  );

  always_comb begin
    fault_next = fault_reg;
    ftype_next = ftype_reg;
    if (faultClear && !mismatch) begin
      fault_next = 1'b0;
      ftype_next = lbes_pkg::FTYPE_NONE;
    end
    if (mismatchLong && mismatch) begin
      fault_next = 1'b1;
      ftype_next = ftype_reg | {chanB, chanA};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_reg <= 1'b0;
      ftype_reg <= lbes_pkg::FTYPE_NONE;
    end else begin
      fault_reg <= fault_next;
      ftype_reg <= ftype_next;
    end
  end

  // ****************************************
  // Run mode and frequency command
  // ****************************************
  lbes_pkg::lbes_mode_e mode_reg, mode_next;
  logic [lbes_pkg::FREQ_W-1:0] freq_reg, freq_next;
  logic [lbes_pkg::RAMP_W-1:0] ramp_reg, ramp_next;
  logic en_reg, en_next;
  logic stoTrip;
  assign stoTrip = chanA && chanB;

  always_comb begin
    if (emergOn) begin
      mode_next = lbes_pkg::MODE_EMERG;
    end else if (maintOn) begin
      mode_next = lbes_pkg::MODE_MAINT;
    end else begin
      mode_next = lbes_pkg::MODE_NORMAL;
    end
    freq_next = normalFreq;
    ramp_next = normalRampSet;
    en_next = runCmd && !stoTrip && !fault_reg;
    unique case (mode_next)
      lbes_pkg::MODE_EMERG: begin
        ramp_next = lbes_pkg::RAMP_SET_EMERG;
        freq_next = emFreq_reg;
        if (handling_reg == lbes_pkg::EMERG_NO_RUN) begin
          freq_next = lbes_pkg::FREQ_ZERO;
          en_next = 1'b0;
        end
      end
      lbes_pkg::MODE_MAINT: begin
        freq_next = mtFreq_reg;
      end
      lbes_pkg::MODE_NORMAL: begin
        freq_next = normalFreq;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_reg <= lbes_pkg::MODE_NORMAL;
      freq_reg <= lbes_pkg::FREQ_ZERO;
      ramp_reg <= '0;
      en_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      freq_reg <= freq_next;
      ramp_reg <= ramp_next;
      en_reg <= en_next;
    end
  end

  // ****************************************
  // Brake opening
  // ****************************************
  logic [lbes_pkg::CNT_W-1:0] pre_reg, pre_next;
  logic brakeCond;
  logic brakeTick;
  logic brakeDone;
  logic freqReached;
  logic currReached;

  always_comb begin
    freqReached = directionReverse ? (outputFreq >= brakeOpenFreqDown) :
                  (outputFreq >= brakeOpenFreqUp);
    currReached = (brakeOpenType == lbes_pkg::BRAKE_BY_FREQ) ||
                  (outputCurrent >= brakeOpenCurrent);
    brakeCond = en_reg && freqReached && currReached;
    brakeTick = (pre_reg == lbes_pkg::CNT_W'(BRAKE_UNIT_CYC - 1));
    pre_next = (!brakeCond || brakeTick) ? '0 : pre_reg + lbes_pkg::CNT_W'(1);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  lbes_delay #(.W(lbes_pkg::TIME_W)) uBrake (
    .clk(clk),
    .reset(reset),
    .run(brakeCond),
    .tick(brakeTick),
    .limit(brakeOpenDelay),
    .done(brakeDone)
  );

  assign brakeOpen = brakeDone;
  assign outputEnable = en_reg;
  assign freqSetpoint = freq_reg;
  assign rampSet = ramp_reg;
  assign runMode = mode_reg;
  assign torqueOffActive = stoTrip;
  assign torqueOffMismatchFault = fault_reg;
  assign faultTypeMonitor = ftype_reg;
  assign emergencyRunFreq = emFreq_reg;
  assign maintenanceRunFreq = mtFreq_reg;
  assign emergencyHandlingSelect = handling_reg;
  assign ascendCorrectionFreq = ascFreq_reg;
  assign descendCorrectionFreq = dscFreq_reg;
  assign emergencyValidTime = vTime_reg;
  assign emergencyInvalidTime = iTime_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_brake_needs_freq: assert property (brakeOpen |-> $past(freqReached))
    else $error("brake open without frequency");
  a_brake_needs_curr: assert property (brakeOpen && brakeOpenType |-> $past(currReached))
    else $error("brake open without current");
  a_emerg_freq_used: assert property (emergOn && handling_reg |=>
    freqSetpoint == $past(emFreq_reg))
    else $error("emergency frequency not used");
  a_emerg_ramp_set: assert property (emergOn |=> rampSet == lbes_pkg::RAMP_SET_EMERG)
    else $error("emergency ramp not selected");
  a_maint_freq_used: assert property (maintOn && !emergOn |=>
    freqSetpoint == $past(mtFreq_reg))
    else $error("maintenance frequency not used");
  a_emerg_precedes: assert property (emergOn |=> runMode == lbes_pkg::MODE_EMERG)
    else $error("maintenance ran over emergency");
  a_emerg_no_output: assert property (emergOn && !handling_reg |=> !outputEnable)
    else $error("output during emergency without UPS");
  a_corr_in_range: assert property (ascendCorrectionFreq <= lbes_pkg::CORR_FREQ_MAX)
    else $error("ascending correction out of range");
  a_dcorr_in_range: assert property (descendCorrectionFreq <= lbes_pkg::CORR_FREQ_MAX)
    else $error("descending correction out of range");
  a_sto_stops_out: assert property (stoTrip |=> !outputEnable ##1 !brakeOpen)
    else $error("output while torque off");
  a_fault_on_mismatch: assert property (mismatchLong && mismatch |=>
    torqueOffMismatchFault && faultTypeMonitor != lbes_pkg::FTYPE_NONE)
    else $error("mismatch fault not raised");
  c_brake_opens: cover property (!brakeOpen ##1 brakeOpen);
  c_emerg_run: cover property (emergOn && handling_reg ##1 outputEnable);
  c_maint_run: cover property (mode_reg == lbes_pkg::MODE_MAINT);
  c_mismatch_fault: cover property ($rose(torqueOffMismatchFault));
endmodule
`default_nettype wire

// file: rtl/lbes_delay.sv
// Delay counter that reports once a run has lasted a given number of ticks
`timescale 1ns/100ps
`default_nettype none
module lbes_delay #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // Status
  output logic done
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    count_next = count_reg;
    done_next = 1'b0;
    if (!run) begin
      count_next = '0;
    end else begin
      if (tick && (count_reg < limit)) begin
        count_next = count_reg + W'(1);
      end
      done_next = (count_reg >= limit);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule
`default_nettype wire

// file: rtl/lbes_pkg.sv
// Shared constants for the lift brake, emergency and torque-off logic
package lbes_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int FREQ_W = 16;
  localparam int TIME_W = 16;
  localparam int CURR_W = 16;
  localparam int RAMP_W = 3;
  localparam int FTYPE_W = 2;
  localparam int CNT_W = 24;
  // ****************************************
  // Frequency parameters, 0.01 Hz units
  // ****************************************
  localparam logic [FREQ_W-1:0] RUN_FREQ_MAX = 16'h1388;
  localparam logic [FREQ_W-1:0] RUN_FREQ_DEF = 16'h07D0;
  localparam logic [FREQ_W-1:0] CORR_FREQ_MAX = 16'h012C;
  localparam logic [FREQ_W-1:0] CORR_FREQ_DEF = 16'h0000;
  localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
  // ****************************************
  // Emergency signal times, 0.1 s units
  // ****************************************
  localparam logic [TIME_W-1:0] VALID_TIME_MAX = 16'h1388;
  localparam logic [TIME_W-1:0] VALID_TIME_DEF = 16'h0064;
  localparam logic [TIME_W-1:0] INVALID_TIME_MAX = 16'h2710;
  localparam logic [TIME_W-1:0] INVALID_TIME_DEF = 16'h0708;
  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic BRAKE_BY_FREQ = 1'h0;
  localparam logic BRAKE_BY_FREQ_CURR = 1'h1;
  localparam logic EMERG_NO_RUN = 1'h0;
  localparam logic EMERG_UPS_RUN = 1'h1;
  localparam logic EMERG_HANDLING_DEF = 1'h1;
  localparam logic [RAMP_W-1:0] RAMP_SET_EMERG = 3'h4;
  localparam logic [FTYPE_W-1:0] FTYPE_NONE = 2'h0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int BRAKE_UNIT_MS = 10;
  localparam int SWITCH_TIME_MS = 250;
  localparam int BRAKE_UNIT_CYCLES = CLK_HZ / 1000 * BRAKE_UNIT_MS;
  localparam int SWITCH_CYCLES = CLK_HZ / 1000 * SWITCH_TIME_MS;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_EMERG, MODE_MAINT} lbes_mode_e;
endpackage

// file: tb/lbes_partner.sv
// Elevator controller and safety switch driving the block's pins
`timescale 1ns/100ps
`default_nettype none
module lbes_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requests from the bench
  input wire logic emergReq,
  input wire logic maintReq,
  input wire logic chanAReq,
  input wire logic chanBReq,
  // Pins
  output logic emergencyPin,
  output logic maintenancePin,
  output logic torqueOffChannelA,
  output logic torqueOffChannelB
);
  logic [2:0] chanBDelay;
  // contact skew far under switch time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      emergencyPin <= 1'b0;
      maintenancePin <= 1'b0;
      torqueOffChannelA <= 1'b0;
      torqueOffChannelB <= 1'b0;
      chanBDelay <= 3'h0;
    end else begin
      emergencyPin <= emergReq;
      maintenancePin <= maintReq;
      torqueOffChannelA <= chanAReq;
      chanBDelay <= {chanBDelay[1:0], chanBReq};
      torqueOffChannelB <= chanBDelay[2];
    end
  end
endmodule
`default_nettype wire

// file: tb/test_lbes_core.sv
// Self-checking testbench for the brake, emergency and torque-off core
`timescale 1ns/100ps
`default_nettype none
module test_lbes_core;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic runCmd = 1'b0, directionReverse = 1'b0, brakeOpenType = 1'b0, paramLoad = 1'b0;
  logic emergencyHandlingSelectIn = 1'b0, faultClear = 1'b0;
  logic emergReq = 1'b0, maintReq = 1'b0, chanAReq = 1'b0, chanBReq = 1'b0;
  logic [15:0] outputFreq = 16'h0000, outputCurrent = 16'h0000, normalFreq = 16'h0FA0;
  logic [15:0] brakeOpenDelay = 16'h0002, brakeOpenFreqUp = 16'h0064;
  logic [15:0] brakeOpenFreqDown = 16'h00C8, brakeOpenCurrent = 16'h0190;
  logic [15:0] emergencyRunFreqIn = 16'h0000, maintenanceRunFreqIn = 16'h0000;
  logic [15:0] ascendCorrectionFreqIn = 16'h0000, descendCorrectionFreqIn = 16'h0000;
  logic [15:0] emergencyValidTimeIn = 16'h0000, emergencyInvalidTimeIn = 16'h0000;
  logic [2:0] normalRampSet = 3'h1;
  logic emergencyPin, maintenancePin, torqueOffChannelA, torqueOffChannelB;
  logic brakeOpen, outputEnable, torqueOffActive, torqueOffMismatchFault;
  logic emergencyHandlingSelect;
  logic [15:0] freqSetpoint, emergencyRunFreq, maintenanceRunFreq, ascendCorrectionFreq;
  logic [15:0] descendCorrectionFreq, emergencyValidTime, emergencyInvalidTime;
  logic [2:0] rampSet;
  logic [1:0] runMode, faultTypeMonitor;
  int mismatches = 0;
  int checksDone = 0;
  always #25 clk = ~clk;
  lbes_partner lbes_partner_inst (.clk, .reset, .emergReq, .maintReq, .chanAReq, .chanBReq,
    .emergencyPin, .maintenancePin, .torqueOffChannelA, .torqueOffChannelB);
  lbes_core #(.BRAKE_UNIT_CYC(4), .SWITCH_CYC(16)) lbes_core_inst (.clk, .reset, .runCmd,
    .directionReverse, .outputFreq, .outputCurrent, .normalFreq, .normalRampSet,
    .brakeOpenType, .brakeOpenDelay, .brakeOpenFreqUp, .brakeOpenFreqDown,
    .brakeOpenCurrent, .paramLoad, .emergencyRunFreqIn, .maintenanceRunFreqIn,
    .emergencyHandlingSelectIn, .ascendCorrectionFreqIn, .descendCorrectionFreqIn,
    .emergencyValidTimeIn, .emergencyInvalidTimeIn, .emergencyPin, .maintenancePin,
    .torqueOffChannelA, .torqueOffChannelB, .faultClear, .brakeOpen, .outputEnable,
    .freqSetpoint, .rampSet, .runMode, .torqueOffActive, .torqueOffMismatchFault,
    .faultTypeMonitor, .emergencyRunFreq, .maintenanceRunFreq, .emergencyHandlingSelect,
    .ascendCorrectionFreq, .descendCorrectionFreq, .emergencyValidTime,
    .emergencyInvalidTime);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic load(input logic [15:0] e, m, input logic h, input logic [15:0] a, d, v, i);
    @(posedge clk);
    paramLoad <= 1'b1;
    emergencyRunFreqIn <= e;
    maintenanceRunFreqIn <= m;
    emergencyHandlingSelectIn <= h;
    ascendCorrectionFreqIn <= a;
    descendCorrectionFreqIn <= d;
    emergencyValidTimeIn <= v;
    emergencyInvalidTimeIn <= i;
    @(posedge clk);
    paramLoad <= 1'b0;
    #1;
  endtask
  task automatic wait_brake(input logic exp, input int lim, input string name);
    int n;
    n = 0;
    #1;
    while (brakeOpen !== exp && n < lim) begin
      cycles(1);
      n++;
    end
    check(name, {15'h0000, brakeOpen}, {15'h0000, exp});
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_params;
    check("emergFreq", emergencyRunFreq, lbes_pkg::RUN_FREQ_DEF);
    check("maintFreq", maintenanceRunFreq, lbes_pkg::RUN_FREQ_DEF);
    check("handling", {15'h0000, emergencyHandlingSelect}, 16'h0001);
    check("ascCorr", ascendCorrectionFreq, lbes_pkg::CORR_FREQ_DEF);
    check("descCorr", descendCorrectionFreq, lbes_pkg::CORR_FREQ_DEF);
    check("validTime", emergencyValidTime, lbes_pkg::VALID_TIME_DEF);
    check("invalidTime", emergencyInvalidTime, lbes_pkg::INVALID_TIME_DEF);
    load(16'hFFFF, 16'h1389, 1'b0, 16'h012D, 16'hFFFF, 16'h1389, 16'h2711);
    check("emergClamp", emergencyRunFreq, lbes_pkg::RUN_FREQ_MAX);
    check("maintClamp", maintenanceRunFreq, lbes_pkg::RUN_FREQ_MAX);
    check("ascClamp", ascendCorrectionFreq, lbes_pkg::CORR_FREQ_MAX);
    check("descClamp", descendCorrectionFreq, lbes_pkg::CORR_FREQ_MAX);
    check("validClamp", emergencyValidTime, lbes_pkg::VALID_TIME_MAX);
    check("invalidClamp", emergencyInvalidTime, lbes_pkg::INVALID_TIME_MAX);
    check("handlingNoRun", {15'h0000, emergencyHandlingSelect}, 16'h0000);
    load(16'h0BB8, 16'h03E8, 1'b1, 16'h0064, 16'h012B, 16'h0000, 16'h270F);
    check("descEdge", descendCorrectionFreq, 16'h012B);
    check("invalidEdge", emergencyInvalidTime, 16'h270F);
    check("emergLoad", emergencyRunFreq, 16'h0BB8);
    check("maintLoad", maintenanceRunFreq, 16'h03E8);
    check("ascLoad", ascendCorrectionFreq, 16'h0064);
    check("validZero", emergencyValidTime, 16'h0000);
    check("handlingUps", {15'h0000, emergencyHandlingSelect}, 16'h0001);
  endtask
  task automatic test_modes;
    @(posedge clk);
    runCmd <= 1'b1;
    cycles(4);
    check("normalFreq", freqSetpoint, 16'h0FA0);
    check("normalEn", {15'h0000, outputEnable}, 16'h0001);
    @(posedge clk);
    emergReq <= 1'b1;
    maintReq <= 1'b1;
    cycles(8);
    check("emergMode", {14'h0000, runMode}, 16'h0001);
    check("emergFreqOut", freqSetpoint, 16'h0BB8);
    check("emergRamp", {13'h0000, rampSet}, {13'h0000, lbes_pkg::RAMP_SET_EMERG});
    check("upsEn", {15'h0000, outputEnable}, 16'h0001);
    @(posedge clk);
    emergReq <= 1'b0;
    cycles(8);
    check("maintMode", {14'h0000, runMode}, 16'h0002);
    check("maintFreqOut", freqSetpoint, 16'h03E8);
    check("maintRamp", {13'h0000, rampSet}, 16'h0001);
    @(posedge clk);
    maintReq <= 1'b0;
    load(16'h0BB8, 16'h03E8, 1'b0, 16'h0064, 16'h012C, 16'h0000, 16'h2710);
    @(posedge clk);
    emergReq <= 1'b1;
    cycles(8);
    check("noRunEn", {15'h0000, outputEnable}, 16'h0000);
    check("noRunFreq", freqSetpoint, 16'h0000);
    @(posedge clk);
    emergReq <= 1'b0;
    cycles(8);
  endtask
  task automatic test_brake;
    @(posedge clk);
    outputFreq <= 16'h0064;
    cycles(5);
    check("brakeEarly", {15'h0000, brakeOpen}, 16'h0000);
    wait_brake(1'b1, 10, "brakeUp");
    @(posedge clk);
    directionReverse <= 1'b1;
    cycles(1);
    wait_brake(1'b0, 4, "brakeRevLow");
    @(posedge clk);
    outputFreq <= 16'h00C8;
    wait_brake(1'b1, 16, "brakeRev");
    @(posedge clk);
    brakeOpenType <= 1'b1;
    outputCurrent <= 16'h018F;
    cycles(20);
    check("brakeLowCurr", {15'h0000, brakeOpen}, 16'h0000);
    @(posedge clk);
    outputCurrent <= 16'h0190;
    wait_brake(1'b1, 16, "brakeCurr");
    @(posedge clk);
    outputFreq <= 16'h0000;
    cycles(4);
  endtask
  task automatic sto_case(input logic a, b, input logic [15:0] fault, type_code, en);
    @(posedge clk);
    chanAReq <= a;
    chanBReq <= b;
    cycles(30);
    check("stoFault", {15'h0000, torqueOffMismatchFault}, fault);
    check("stoType", {14'h0000, faultTypeMonitor}, type_code);
    check("stoEn", {15'h0000, outputEnable}, en);
  endtask
  task automatic clear_fault;
    @(posedge clk);
    chanAReq <= 1'b0;
    chanBReq <= 1'b0;
    cycles(10);
    @(posedge clk);
    faultClear <= 1'b1;
    @(posedge clk);
    faultClear <= 1'b0;
    cycles(4);
    check("cleared", {15'h0000, torqueOffMismatchFault}, 16'h0000);
    check("clearedEn", {15'h0000, outputEnable}, 16'h0001);
  endtask
  task automatic test_sto;
    sto_case(1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0000);
    check("stoActive", {15'h0000, torqueOffActive}, 16'h0001);
    sto_case(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0001);
    check("stoIdle", {15'h0000, torqueOffActive}, 16'h0000);
    sto_case(1'b1, 1'b0, 16'h0001, 16'h0001, 16'h0000);
    sto_case(1'b0, 1'b1, 16'h0001, 16'h0003, 16'h0000);
    clear_fault();
    sto_case(1'b0, 1'b1, 16'h0001, 16'h0002, 16'h0000);
    clear_fault();
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    cycles(1);
    test_params();
    test_modes();
    test_brake();
    test_sto();
    print_verdict();
  end
  initial begin
    #(50 * 5000);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
